// ### common/ccr_pkg.sv
// Constants for the per-channel codec configuration register group
`default_nettype none
package ccr_pkg;
   localparam int NUM_CHAN = 4;
   localparam int NUM_PINS = 5;
   localparam int NUM_FILT = 6;
   // Command byte offsets, write form; read form sets bit 0
   localparam logic [7:0] OFF_GAIN = 8'h50;
   localparam logic [7:0] OFF_PIN_DATA = 8'h52;
   localparam logic [7:0] OFF_PIN_DIR = 8'h54;
   localparam logic [7:0] OFF_OPFUNC = 8'h60;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h6C;
   localparam int CMD_RW_BIT = 0;
   // Reset values
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [7:0] RST_PIN_DATA = 8'h00;
   localparam logic [7:0] RST_PIN_DIR = 8'h00;
   localparam logic [7:0] RST_OPFUNC = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
   // Gain register fields
   localparam int GAIN_ATTEN_DIS_BIT = 7;
   localparam int GAIN_TX_BIT = 6;
   localparam int GAIN_RX_BIT = 5;
   localparam logic [4:0] SCALE_OFFSET = 5'h10;
   localparam logic [4:0] SCALE_LOOPBACK = 5'h10;
   localparam logic [4:0] SCALE_CUTOFF = 5'h00;
   // Pin data register fields
   localparam int DATA_OUT_SEVEN_BIT = 7;
   localparam int DATA_OUT_SIX_BIT = 6;
   localparam int DATA_MUX_BIT = 5;
   // Direction register fields
   localparam int DIR_ACTIVE_BIT = 6;
   localparam int DIR_FAIL_BIT = 5;
   localparam logic [7:0] DIR_WRITE_MASK = 8'h1F;
   // Operating functions fields
   localparam int OP_LINEAR_BIT = 7;
   localparam int OP_MULAW_BIT = 6;

   typedef enum {SEL_NONE, SEL_GAIN, SEL_DATA, SEL_DIR, SEL_OPFUNC}
      ccr_sel_e;

   // Pin data byte: bit 5 is the mux bit, so pins sit at 4..2 and 1..0
   function automatic logic [4:0] pinField(input logic [7:0] b);
      pinField = {b[4:2], b[1:0]};
   endfunction : pinField
endpackage : ccr_pkg
`default_nettype wire

// ### common/ccr_cmd_if.sv
// Write path from the command decoder to the channel register banks
`default_nettype none
interface ccr_cmd_if;
   logic wrStrobe;
   ccr_pkg::ccr_sel_e wrSel;
   logic [7:0] wrData;
   modport decoder (output wrStrobe, output wrSel, output wrData);
   modport bank (input wrStrobe, input wrSel, input wrData);
endinterface : ccr_cmd_if
`default_nettype wire

// ### rtl/ccr_channel_bank.sv
// One channel's copy of the gain, pin data, direction and function registers
`default_nettype none
module ccr_channel_bank (
   input wire logic clock,
   input wire logic rst_b,
   ccr_cmd_if.bank cmd,
   input wire logic chanEn,
   output logic [7:0] gain_r,
   output logic [7:0] pinData_r,
   output logic [7:0] pinDir_r,
   output logic [7:0] opFunc_r
);
   logic wrOk;
   assign wrOk = cmd.wrStrobe && chanEn;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         gain_r <= ccr_pkg::RST_GAIN;
      end else if (wrOk && cmd.wrSel == ccr_pkg::SEL_GAIN) begin
         gain_r <= cmd.wrData;
      end
   end

   // Latched even for pins set as inputs; the top decides what drives
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pinData_r <= ccr_pkg::RST_PIN_DATA;
      end else if (wrOk && cmd.wrSel == ccr_pkg::SEL_DATA) begin
         pinData_r <= cmd.wrData;
      end
   end

   // Status and reserved bits are not storage and are dropped on write
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pinDir_r <= ccr_pkg::RST_PIN_DIR;
      end else if (wrOk && cmd.wrSel == ccr_pkg::SEL_DIR) begin
         pinDir_r <= cmd.wrData & ccr_pkg::DIR_WRITE_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         opFunc_r <= ccr_pkg::RST_OPFUNC;
      end else if (wrOk && cmd.wrSel == ccr_pkg::SEL_OPFUNC) begin
         opFunc_r <= cmd.wrData;
      end
   end
endmodule : ccr_channel_bank
`default_nettype wire

// ### rtl/ccr_regs_top.sv
// Per-channel configuration registers of a four-channel codec group
`default_nettype none
module ccr_regs_top #(
   parameter int NCH = ccr_pkg::NUM_CHAN,
   parameter int NPIN = ccr_pkg::NUM_PINS,
   parameter int NFLT = ccr_pkg::NUM_FILT
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic cmdValid,
   input wire logic [7:0] cmdByte,
   input wire logic [7:0] cmdData,
   input wire logic [NCH-1:0] chanEnable,
   input wire logic [NCH-1:0] chanActive,
   input wire logic clockLockFail,
   input wire logic e1MuxEnable,
   input wire logic [2*NCH-1:0] rtDataChange,
   input wire logic [NCH*NPIN-1:0] ctrlPinIn,
   output logic rdValid,
   output logic [7:0] rdData,
   output logic [NCH*NPIN-1:0] ctrlPinOut,
   output logic [NCH*NPIN-1:0] ctrlPinOe_b,
   output logic [NCH*NPIN-1:0] ctrlPinLevel,
   output logic [2*NCH-1:0] ctrlOutHigh,
   output logic [NCH-1:0] ctrlOneMuxBit,
   output logic [NCH-1:0] inputAttenOff,
   output logic [NCH-1:0] txGainOn,
   output logic [NCH-1:0] rxLossOn,
   output logic [6*NCH-1:0] scaleGain,
   output logic [NCH-1:0] loopbackOn,
   output logic [NCH-1:0] scaleCutoff,
   output logic [NCH-1:0] linearCode,
   output logic [NCH-1:0] muLawCode,
   output logic [NFLT*NCH-1:0] filterProgSel,
   output logic [2*NCH-1:0] rtIrqEvent
);
   ccr_cmd_if cmd ();

   logic [7:0] gainQ [NCH];
   logic [7:0] dataQ [NCH];
   logic [7:0] dirQ [NCH];
   logic [7:0] opQ [NCH];
   logic [7:0] irqMask_r;
   logic [NCH*NPIN-1:0] pinMeta_r;
   logic cmdRead;
   ccr_pkg::ccr_sel_e sel;
   logic selMask;
   logic anyEn;
   int rdCh;

   // Scale code to signed gain in sixteenths of the attenuator gain
   function automatic logic [5:0] scaleOf(input logic [4:0] code);
      scaleOf = {1'b0, code} - {1'b0, ccr_pkg::SCALE_OFFSET};
   endfunction : scaleOf

   // Upper seven bits pick the register, bit 0 picks read or write
   function automatic logic hit(input logic [7:0] c, input logic [7:0] off);
      hit = (c[7:1] == off[7:1]);
   endfunction : hit

   always_comb begin
      sel = ccr_pkg::SEL_NONE;
      if (hit(cmdByte, ccr_pkg::OFF_GAIN)) begin
         sel = ccr_pkg::SEL_GAIN;
      end else if (hit(cmdByte, ccr_pkg::OFF_PIN_DATA)) begin
         sel = ccr_pkg::SEL_DATA;
      end else if (hit(cmdByte, ccr_pkg::OFF_PIN_DIR)) begin
         sel = ccr_pkg::SEL_DIR;
      end else if (hit(cmdByte, ccr_pkg::OFF_OPFUNC)) begin
         sel = ccr_pkg::SEL_OPFUNC;
      end
   end
   assign selMask = hit(cmdByte, ccr_pkg::OFF_IRQ_MASK);
   assign cmdRead = cmdByte[ccr_pkg::CMD_RW_BIT];
   assign anyEn = |chanEnable;

   assign cmd.wrStrobe = cmdValid && !cmdRead;
   assign cmd.wrSel = sel;
   assign cmd.wrData = cmdData;

   for (genvar c = 0; c < NCH; c++) begin : g_chan
      ccr_channel_bank u_bank (
         .clock(clock),
         .rst_b(rst_b),
         .cmd(cmd),
         .chanEn(chanEnable[c]),
         .gain_r(gainQ[c]),
         .pinData_r(dataQ[c]),
         .pinDir_r(dirQ[c]),
         .opFunc_r(opQ[c])
      );
   end

   // Lowest enabled channel answers reads when several are enabled
   always_comb begin
      rdCh = 0;
      for (int c = NCH - 1; c >= 0; c--) begin
         if (chanEnable[c]) begin
            rdCh = c;
         end
      end
   end

   // Mask register does not depend on the channel enables
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irqMask_r <= ccr_pkg::RST_IRQ_MASK;
      end else if (cmdValid && !cmdRead && selMask) begin
         irqMask_r <= cmdData;
      end
   end

   // Read answer one cycle after the command byte
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdValid <= 1'b0;
         rdData <= 8'h00;
      end else begin
         rdValid <= cmdValid && cmdRead;
         rdData <= 8'h00;
         if (cmdValid && cmdRead) begin
            if (selMask) begin
               rdData <= irqMask_r;
            end else if (sel == ccr_pkg::SEL_DIR) begin
               rdData[ccr_pkg::DIR_FAIL_BIT] <= clockLockFail;
               if (anyEn) begin
                  rdData[4:0] <= dirQ[rdCh][4:0];
                  rdData[ccr_pkg::DIR_ACTIVE_BIT] <= chanActive[rdCh];
               end
            end else if (anyEn) begin
               case (sel)
                  ccr_pkg::SEL_GAIN: rdData <= gainQ[rdCh];
                  ccr_pkg::SEL_DATA: rdData <= dataQ[rdCh];
                  ccr_pkg::SEL_OPFUNC: rdData <= opQ[rdCh];
                  default: rdData <= 8'h00;
               endcase
            end
         end
      end
   end

   // Two-flop synchroniser on the bidirectional pin levels
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pinMeta_r <= '0;
         ctrlPinLevel <= '0;
      end else begin
         pinMeta_r <= ctrlPinIn;
         ctrlPinLevel <= pinMeta_r;
      end
   end

   // Pin drive: enable is low while driving
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ctrlPinOut <= '0;
         ctrlPinOe_b <= '1;
         ctrlOutHigh <= '0;
         ctrlOneMuxBit <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            ctrlPinOut[c*NPIN +: NPIN] <= ccr_pkg::pinField(dataQ[c]);
            ctrlPinOe_b[c*NPIN +: NPIN] <= ~dirQ[c][NPIN-1:0];
            ctrlOutHigh[2*c +: 2] <= dataQ[c][7:6];
            ctrlOneMuxBit[c] <= e1MuxEnable &&
               dataQ[c][ccr_pkg::DATA_MUX_BIT];
         end
      end
   end

   // Analog gain and scaling controls
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         inputAttenOff <= '0;
         txGainOn <= '0;
         rxLossOn <= '0;
         scaleGain <= '0;
         loopbackOn <= '0;
         scaleCutoff <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            inputAttenOff[c] <= gainQ[c][ccr_pkg::GAIN_ATTEN_DIS_BIT];
            txGainOn[c] <= gainQ[c][ccr_pkg::GAIN_TX_BIT];
            rxLossOn[c] <= gainQ[c][ccr_pkg::GAIN_RX_BIT];
            scaleGain[6*c +: 6] <= scaleOf(gainQ[c][4:0]);
            loopbackOn[c] <= gainQ[c][4:0] == ccr_pkg::SCALE_LOOPBACK;
            scaleCutoff[c] <= gainQ[c][4:0] == ccr_pkg::SCALE_CUTOFF;
         end
      end
   end

   // Coding law and filter coefficient source
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         linearCode <= '0;
         muLawCode <= '0;
         filterProgSel <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            linearCode[c] <= opQ[c][ccr_pkg::OP_LINEAR_BIT];
            muLawCode[c] <= opQ[c][ccr_pkg::OP_MULAW_BIT];
            filterProgSel[NFLT*c +: NFLT] <= opQ[c][NFLT-1:0];
         end
      end
   end

   // Only unmasked changes reach the interrupt logic
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rtIrqEvent <= '0;
      end else begin
         rtIrqEvent <= rtDataChange & ~irqMask_r;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence s_readCmd;
      cmdValid && cmdRead;
   endsequence
   sequence s_gainWrite;
      cmdValid && !cmdRead && sel == ccr_pkg::SEL_GAIN && chanEnable[0];
   endsequence
   sequence s_dataWrite;
      cmdValid && !cmdRead && sel == ccr_pkg::SEL_DATA && chanEnable[0];
   endsequence
   sequence s_opWrite;
      cmdValid && !cmdRead && sel == ccr_pkg::SEL_OPFUNC && chanEnable[0];
   endsequence

   AST_READ_ANSWER: assert property (
      s_readCmd |=> rdValid)
      else $error("Read command got no answer");
   AST_NO_SPURIOUS_READ: assert property (
      !(cmdValid && cmdRead) |=> !rdValid)
      else $error("Answer without read command");
   AST_GAIN_TO_TX: assert property (
      s_gainWrite ##1 1'b1 |=> txGainOn[0] == $past(cmdData[6], 2))
      else $error("Transmit gain not following write");
   AST_ATTEN: assert property (
      s_gainWrite ##1 1'b1 |=> inputAttenOff[0] == $past(cmdData[7], 2))
      else $error("Attenuator control not following write");
   AST_DISABLED_IGNORE: assert property (
      cmdValid && !cmdRead && !chanEnable[0] |=> $stable(gainQ[0]))
      else $error("Disabled channel took a write");
   AST_FAIL_READ: assert property (
      cmdValid && cmdRead && sel == ccr_pkg::SEL_DIR
      |=> rdData[ccr_pkg::DIR_FAIL_BIT] == $past(clockLockFail))
      else $error("Clock fail bit misread");
   AST_INPUT_NOT_DRIVEN: assert property (
      !dirQ[0][0] |=> ctrlPinOe_b[0])
      else $error("Input pin driven");
   AST_MUX_GATED: assert property (
      !e1MuxEnable |=> !ctrlOneMuxBit[0])
      else $error("Mux bit active without E1 option");
   AST_MASKED_QUIET: assert property (
      irqMask_r[0] && rtDataChange[0] |=> !rtIrqEvent[0])
      else $error("Masked change raised interrupt");
   AST_LOOPBACK: assert property (
      gainQ[1][4:0] == ccr_pkg::SCALE_LOOPBACK |=> loopbackOn[1])
      else $error("Loopback code not decoded");
   AST_DIR_RESERVED: assert property (
      dirQ[2][7:5] == 3'h0)
      else $error("Direction status bits stored");
   AST_RX_LOSS: assert property (
      s_gainWrite ##1 1'b1 |=> rxLossOn[0] == $past(cmdData[5], 2))
      else $error("Receive loss not following write");
   AST_SCALE_GAIN: assert property (
      s_gainWrite ##1 1'b1 |=> scaleGain[5:0] ==
      {1'b0, $past(cmdData[4:0], 2)} - {1'b0, ccr_pkg::SCALE_OFFSET})
      else $error("Scale gain not code minus offset");
   AST_HIGH_OUTS: assert property (
      s_dataWrite ##1 1'b1 |=> ctrlOutHigh[1:0] == $past(cmdData[7:6], 2))
      else $error("Upper control outputs not following write");
   AST_CODING: assert property (
      s_opWrite ##1 1'b1 |=> linearCode[0] == $past(cmdData[7], 2))
      else $error("Coding select not following write");
   AST_FILTER_SRC: assert property (
      s_opWrite ##1 1'b1 |=> filterProgSel[5:0] == $past(cmdData[5:0], 2))
      else $error("Filter source not following write");
   AST_MASK_WRITE: assert property (
      cmdValid && !cmdRead && selMask |=> irqMask_r == $past(cmdData))
      else $error("Mask register did not take write");
   AST_OUTPUT_DRIVEN: assert property (
      dirQ[0][0] |=> !ctrlPinOe_b[0])
      else $error("Output pin not driven");
endmodule : ccr_regs_top
`default_nettype wire

// ### test/ccr_host_model.sv
// Host processor model issuing command bytes to the register group
`default_nettype none
module ccr_host_model (
   input wire logic clock,
   output var logic cmdValid,
   output var logic [7:0] cmdByte,
   output var logic [7:0] cmdData,
   input wire logic rdValid,
   input wire logic [7:0] rdData
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cmdValid = 1'b0;
      cmdByte = 8'h00;
      cmdData = 8'h00;
   end
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      @(posedge clock);
      cmdValid <= 1'b1;
      cmdByte <= {off[7:1], 1'b0};
      // Status and reserved bits of the direction byte go out as zero
      cmdData <= (off == 8'h54) ? (d & 8'h1F) : d;
      @(posedge clock);
      cmdValid <= 1'b0;
      // Released lines carry junk so a stale value is never trusted
      cmdByte <= ~cmdByte;
      cmdData <= ~cmdData;
   endtask : wr
   // Answer latency is fixed at one cycle, so no open wait here
   task automatic rd(input logic [7:0] off, output logic [7:0] v,
                     output bit ok);
      ok = 1'b0;
      v = 8'h00;
      @(posedge clock);
      cmdValid <= 1'b1;
      cmdByte <= {off[7:1], 1'b1};
      cmdData <= ~cmdData;
      @(posedge clock);
      cmdValid <= 1'b0;
      cmdByte <= ~cmdByte;
      #1;
      if (rdValid === 1'b1) begin
         v = rdData;
         ok = 1'b1;
      end
   endtask : rd
endmodule : ccr_host_model
`default_nettype wire

// ### test/ccr_testbench.sv
// Self-checking bench for the channel configuration registers
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic cmdValid, rdValid, e1MuxEnable = 1'b0, clockLockFail = 1'b0;
   logic [7:0] cmdByte, cmdData, rdData, rtDataChange = 8'h00;
   logic [7:0] rtIrqEvent, ctrlOutHigh;
   logic [3:0] chanEnable = 4'hF, chanActive = 4'h0, ctrlOneMuxBit;
   logic [3:0] inputAttenOff, txGainOn, rxLossOn, loopbackOn;
   logic [3:0] scaleCutoff, linearCode, muLawCode;
   logic [19:0] ctrlPinIn = 20'h00000, ctrlPinOut, ctrlPinOe_b;
   logic [19:0] ctrlPinLevel;
   logic [23:0] scaleGain, filterProgSel;
   logic [7:0] gainM[4], dataM[4], dirM[4], opM[4], maskM;
   logic [7:0] offs[6] = '{8'h50, 8'h52, 8'h54, 8'h60, 8'h6C, 8'h56};
   integer seed;
   int numErrors = 0;
   int cmpCount = 0;
   always #25 clock = ~clock;
   ccr_host_model host_u (.clock(clock), .cmdValid(cmdValid),
      .cmdByte(cmdByte), .cmdData(cmdData), .rdValid(rdValid),
      .rdData(rdData));
   ccr_regs_top dut_u (.clock(clock), .rst_b(rst_b), .cmdValid(cmdValid),
      .cmdByte(cmdByte), .cmdData(cmdData), .chanEnable(chanEnable),
      .chanActive(chanActive), .clockLockFail(clockLockFail),
      .e1MuxEnable(e1MuxEnable), .rtDataChange(rtDataChange),
      .ctrlPinIn(ctrlPinIn), .rdValid(rdValid), .rdData(rdData),
      .ctrlPinOut(ctrlPinOut), .ctrlPinOe_b(ctrlPinOe_b),
      .ctrlPinLevel(ctrlPinLevel), .ctrlOutHigh(ctrlOutHigh),
      .ctrlOneMuxBit(ctrlOneMuxBit), .inputAttenOff(inputAttenOff),
      .txGainOn(txGainOn), .rxLossOn(rxLossOn), .scaleGain(scaleGain),
      .loopbackOn(loopbackOn), .scaleCutoff(scaleCutoff),
      .linearCode(linearCode), .muLawCode(muLawCode),
      .filterProgSel(filterProgSel), .rtIrqEvent(rtIrqEvent));
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmpCount++;
      if (g !== e) begin
         numErrors++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   // Reads answer from the lowest enabled channel
   function automatic logic [7:0] expRd(input logic [7:0] off);
      int c;
      int lo;
      lo = -1;
      for (c = 3; c >= 0; c--) if (chanEnable[c]) lo = c;
      if (off == 8'h6C) return maskM;
      if (lo < 0) return (off == 8'h54) ? {2'b00, clockLockFail, 5'h00} : 0;
      case (off)
         8'h50: return gainM[lo];
         8'h52: return dataM[lo];
         8'h54: return {1'b0, chanActive[lo], clockLockFail, dirM[lo][4:0]};
         8'h60: return opM[lo];
         default: return 8'h00;
      endcase
   endfunction : expRd
   task automatic modelWr(input logic [7:0] off, input logic [7:0] d);
      int c;
      if (off == 8'h6C) maskM = d;
      for (c = 0; c < 4; c++) begin
         if (chanEnable[c]) begin
            case (off)
               8'h50: gainM[c] = d;
               8'h52: dataM[c] = d;
               8'h54: dirM[c] = d & 8'h1F;
               8'h60: opM[c] = d;
               default: ;
            endcase
         end
      end
   endtask : modelWr
   task automatic doRd(input logic [7:0] off);
      logic [7:0] v;
      bit ok;
      host_u.rd(off, v, ok);
      if (!ok) begin
         numErrors++;
         $display("unexpected rdValid: expected 1 seen 0");
      end else begin
         chk("rdData", expRd(off), v);
      end
   endtask : doRd
   task automatic checkOut();
      logic [19:0] eo, eoe;
      logic [23:0] es, ef;
      logic [7:0] eh;
      logic [3:0] ea, et, er, el, ecut, elin, emu, emux;
      int c;
      for (c = 0; c < 4; c++) begin
         eo[c*5+:5] = dataM[c][4:0];
         eoe[c*5+:5] = ~dirM[c][4:0];
         eh[c*2+:2] = dataM[c][7:6];
         emux[c] = dataM[c][5] & e1MuxEnable;
         {ea[c], et[c], er[c]} = gainM[c][7:5];
         es[c*6+:6] = {1'b0, gainM[c][4:0]} - 6'h10;
         el[c] = (gainM[c][4:0] == 5'h10);
         ecut[c] = (gainM[c][4:0] == 5'h00);
         {elin[c], emu[c]} = opM[c][7:6];
         ef[c*6+:6] = opM[c][5:0];
      end
      chk("ctrlPinOut", eo, ctrlPinOut);
      chk("ctrlPinOe_b", eoe, ctrlPinOe_b);
      chk("ctrlOutHigh", eh, ctrlOutHigh);
      chk("ctrlOneMuxBit", emux, ctrlOneMuxBit);
      chk("inputAttenOff", ea, inputAttenOff);
      chk("txGainOn", et, txGainOn);
      chk("rxLossOn", er, rxLossOn);
      chk("scaleGain", es, scaleGain);
      chk("loopbackOn", el, loopbackOn);
      chk("scaleCutoff", ecut, scaleCutoff);
      chk("linearCode", elin, linearCode);
      chk("muLawCode", emu, muLawCode);
      chk("filterProgSel", ef, filterProgSel);
   endtask : checkOut
   task automatic resetAll();
      int c;
      // At start reset is already low, so only two edges see it
      if (rst_b) @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      for (c = 0; c < 4; c++) begin
         {gainM[c], dataM[c], dirM[c], opM[c]} = 32'h00000000;
      end
      maskM = 8'hFF;
      for (c = 0; c < 6; c++) doRd(offs[c]);
      checkOut();
   endtask : resetAll
   initial begin
      logic [31:0] r, s;
      int n;
      seed = 32'h7BDFDEE0;
      resetAll();
      for (n = 0; n < 400; n++) begin
         r = $random(seed);
         s = $random(seed);
         @(posedge clock);
         {chanEnable, chanActive} <= r[7:0];
         {clockLockFail, e1MuxEnable} <= r[9:8];
         ctrlPinIn <= r[31:12];
         rtDataChange <= s[7:0];
         @(posedge clock);
         rtDataChange <= 8'h00;
         #1;
         chk("rtIrqEvent", s[7:0] & ~maskM, rtIrqEvent);
         repeat (3) @(posedge clock);
         #1;
         chk("ctrlPinLevel", ctrlPinIn, ctrlPinLevel);
         checkOut();
         if (s[8]) begin
            host_u.wr(offs[s[18:16] % 6], s[31:24]);
            modelWr(offs[s[18:16] % 6], (offs[s[18:16] % 6] == 8'h54) ?
                    (s[31:24] & 8'h1F) : s[31:24]);
            @(posedge clock);
            #1;
            checkOut();
         end else begin
            doRd(offs[s[18:16] % 6]);
         end
      end
      resetAll();
      summarize();
   end
endmodule : testbench
`default_nettype wire
